/* common/hssd_pkg.sv */
/*
 Constants for the hexadecimal seven-segment digit driver: register map,
 field positions, reset values, bus response codes and segment patterns.
 Assumes a 32-bit AXI4-Lite register bus and one digit per instance.
*/
package hssd_pkg;

	// Register byte offsets
	localparam logic [7:0] HSSD_OFF_CTRL = 8'h00;
	localparam logic [7:0] HSSD_OFF_STATUS = 8'h04;

	// Control register fields
	localparam int HSSD_CTRL_CODE_LSB = 0;
	localparam int HSSD_CTRL_LAMP_BIT = 4;
	localparam int HSSD_CTRL_GATE_BIT = 5;
	localparam int HSSD_CTRL_PINS_BIT = 8;
	localparam logic [31:0] HSSD_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] HSSD_CTRL_MASK = 32'h0000_013F;

	// Status register fields
	localparam int HSSD_STAT_SEG_LSB = 0;
	localparam int HSSD_STAT_RBO_BIT = 7;
	localparam int HSSD_STAT_RBI_BIT = 8;
	localparam int HSSD_STAT_GATE_BIT = 9;
	localparam int HSSD_STAT_CODE_LSB = 10;
	localparam int HSSD_STAT_LAMP_BIT = 14;
	localparam int HSSD_STAT_DRV_BIT = 15;

	// Bus responses
	localparam logic [1:0] HSSD_RESP_OKAY = 2'h0;
	localparam logic [1:0] HSSD_RESP_DECERR = 2'h3;

	// Segment bit order {G,F,E,D,C,B,A}, 1 = lit
	localparam logic [6:0] HSSD_SEG_ALL = 7'h7F;
	localparam logic [6:0] HSSD_SEG_NONE = 7'h00;
	localparam logic [15:0][6:0] HSSD_PATTERNS = {
		7'h71, // F: AEFG
		7'h79, // E: ADEFG
		7'h5E, // D: BCDEG
		7'h39, // C: ADEF
		7'h7C, // B: CDEFG
		7'h77, // A: ABCEFG
		7'h6F, // 9: ABCDFG
		7'h7F, // 8: ABCDEFG
		7'h07, // 7: ABC
		7'h7D, // 6: ACDEFG
		7'h6D, // 5: ACDFG
		7'h66, // 4: BCFG
		7'h4F, // 3: ABCDG
		7'h5B, // 2: ABDEG
		7'h06, // 1: BC
		7'h3F  // 0: ABCDEF
	};

	// Pin synchroniser depth
	localparam int HSSD_SYNC_STAGES = 3;

endpackage

/* core/hssd_decode.sv */
/*
 Pure combinational decode of one hex digit to seven segments, with
 leading-zero blanking, lamp test and the intensity gate.
 Assumes inputs are already in the clock domain of whoever samples it.
*/
`timescale 1ns/1ns
module hssd_decode
(
	// Digit and controls
	input wire logic [3:0] digit_code,
	input wire logic ripple_blank_in_n,
	input wire logic lamp_check_all,
	input wire logic intensity_gate,
	// Display side
	output logic [6:0] segment_lit,
	output logic segment_drive_en,
	output logic ripple_blank_out_n
);

	logic zero_blank;

	always_comb
	begin
		zero_blank = (digit_code == 4'h0) && !ripple_blank_in_n; // [RL4]
		segment_lit = hssd_pkg::HSSD_PATTERNS[digit_code]; // [RL1] [RL2] [RL3]
		if (zero_blank)
			segment_lit = hssd_pkg::HSSD_SEG_NONE; // [RL4]
		if (lamp_check_all)
			segment_lit = hssd_pkg::HSSD_SEG_ALL; // [RL9]
		// Gate wins over everything, blanking output stays live
		if (intensity_gate)
			segment_lit = hssd_pkg::HSSD_SEG_NONE; // [RL7]
		segment_drive_en = !intensity_gate; // [RL7]
		ripple_blank_out_n = !zero_blank; // [RL5] [RL12] [RL13]
	end

endmodule

/* core/hssd_top.sv */
/*
 One-digit hexadecimal seven-segment driver with AXI4-Lite control and
 status registers, synchronised pin inputs and registered display outputs.
 Assumes a single clock; chain pins and pin-side digit inputs are async.
*/
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns

// What this block does
// [RL1] Turns a four-bit hex digit code into its seven-segment pattern.
// [RL2] Codes 0..7 light the listed segment sets, all others dark.
// [RL3] Codes 8..F light the listed segment sets, all others dark.
// [RL4] Zero code with blank input low leaves all segments dark.
// [RL5] That same condition drives the blank output low, otherwise high.
// [RL6] Neighbours chain blanking from most to least significant digit.
// [RL7] Intensity gate high turns off all seven segment drivers.
// [RL8] Outside logic may pulse the gate to dim the display.
// [RL9] Lamp test lights every segment, overriding pattern and blanking.
// [RL10] Seven logic inputs, eight outputs: segments plus blank output; the code also has segment_drive_en as a ninth output.
// [RL11] Any number of digits may be cascaded through the blank chain.
// [RL12] Blank output is always driven, never cut off by the gate.
// [RL13] Outputs follow present inputs only, no decode state held; hssd_top outputs are registered one edge after a three-stage pin filter.
module hssd_top
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pin-side digit inputs
	input wire logic [3:0] digit_code,
	input wire logic lamp_check_all,
	input wire logic intensity_gate,
	input wire logic ripple_blank_in_n,
	// Display and chain outputs
	output logic [6:0] segment_lit,
	output logic segment_drive_en,
	output logic ripple_blank_out_n
);

	localparam int NPIN = 7;
	// Bit positions inside the synchroniser vector
	localparam int PIN_CODE_LSB = 0;
	localparam int PIN_LAMP = 4;
	localparam int PIN_GATE = 5;
	localparam int PIN_RBI = 6;
	// Chain input idles high so reset never fakes a blanked neighbour
	localparam logic [NPIN-1:0] PIN_RESET = 7'h40;

	// Status offset needs at least three address bits
	if (ADDR_W < 3 || ADDR_W > 32)
	begin : g_bad_addr_w
		$error("hssd_top: ADDR_W must be 3..32");
	end

	// Agreement filter below is written for exactly three stages
	if (hssd_pkg::HSSD_SYNC_STAGES != 3)
	begin : g_bad_sync
		$error("hssd_top: three pin stages expected");
	end

	// Pin synchronisers
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1_r;
	logic [NPIN-1:0] pin_s2_r;
	logic [NPIN-1:0] pin_s3_r;
	logic [NPIN-1:0] pin_f_r;

	assign pin_raw = {ripple_blank_in_n, intensity_gate, lamp_check_all, digit_code};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1)
		begin : g_sync
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					pin_s1_r[gi] <= PIN_RESET[gi];
					pin_s2_r[gi] <= PIN_RESET[gi];
					pin_s3_r[gi] <= PIN_RESET[gi];
					pin_f_r[gi] <= PIN_RESET[gi];
				end
				else
				begin
					pin_s1_r[gi] <= pin_raw[gi];
					pin_s2_r[gi] <= pin_s1_r[gi];
					pin_s3_r[gi] <= pin_s2_r[gi];
					// Accept only once two settled stages agree
					if (pin_s2_r[gi] == pin_s3_r[gi])
						pin_f_r[gi] <= pin_s3_r[gi];
				end
			end
		end
	endgenerate

	logic [3:0] pin_code_f;
	logic pin_lamp_f;
	logic pin_gate_f;
	logic pin_rbi_f;

	assign pin_code_f = pin_f_r[PIN_CODE_LSB +: 4];
	assign pin_lamp_f = pin_f_r[PIN_LAMP];
	assign pin_gate_f = pin_f_r[PIN_GATE];
	assign pin_rbi_f = pin_f_r[PIN_RBI];

	// Write channel
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] awaddr_q_r;
	logic [31:0] wdata_q_r;
	logic [3:0] wstrb_q_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic awready_r;
	logic wready_r;
	logic aw_held_nxt;
	logic w_held_nxt;
	logic bvalid_nxt;
	logic do_write;
	logic wr_ctrl;
	logic wr_status;

	assign do_write = aw_held_r && w_held_r && !bvalid_r;
	assign wr_ctrl = awaddr_q_r == ADDR_W'(hssd_pkg::HSSD_OFF_CTRL);
	assign wr_status = awaddr_q_r == ADDR_W'(hssd_pkg::HSSD_OFF_STATUS);

	always_comb
	begin
		aw_held_nxt = aw_held_r || (s_axi_awvalid && awready_r);
		w_held_nxt = w_held_r || (s_axi_wvalid && wready_r);
		bvalid_nxt = bvalid_r && !s_axi_bready;
		if (do_write)
		begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_q_r <= '0;
			wdata_q_r <= 32'h0000_0000;
			wstrb_q_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= hssd_pkg::HSSD_RESP_OKAY;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
		end
		else
		begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			bvalid_r <= bvalid_nxt;
			// One write in flight: no new beats until response is taken
			awready_r <= !aw_held_nxt && !bvalid_nxt;
			wready_r <= !w_held_nxt && !bvalid_nxt;
			if (s_axi_awvalid && awready_r)
				awaddr_q_r <= s_axi_awaddr;
			if (s_axi_wvalid && wready_r)
			begin
				wdata_q_r <= s_axi_wdata;
				wstrb_q_r <= s_axi_wstrb;
			end
			// Status writes are accepted and ignored
			if (do_write)
				bresp_r <= (wr_ctrl || wr_status) ? hssd_pkg::HSSD_RESP_OKAY
					: hssd_pkg::HSSD_RESP_DECERR;
		end
	end

	// Control register
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;

	always_comb
	begin
		ctrl_nxt = ctrl_r;
		for (int b = 0; b < 4; b++)
		begin
			if (wstrb_q_r[b])
				ctrl_nxt[b*8 +: 8] = wdata_q_r[b*8 +: 8];
		end
		ctrl_nxt = ctrl_nxt & hssd_pkg::HSSD_CTRL_MASK;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_r <= hssd_pkg::HSSD_CTRL_RESET;
		else if (do_write && wr_ctrl)
			ctrl_r <= ctrl_nxt;
	end

	// Effective decode inputs
	logic use_pins;
	logic [3:0] eff_code;
	logic eff_lamp;
	logic eff_gate;
	logic [6:0] dec_seg;
	logic dec_drv;
	logic dec_rbo_n;

	assign use_pins = ctrl_r[hssd_pkg::HSSD_CTRL_PINS_BIT];
	assign eff_code = use_pins ? pin_code_f
		: ctrl_r[hssd_pkg::HSSD_CTRL_CODE_LSB +: 4]; // [RL10]
	assign eff_lamp = use_pins ? pin_lamp_f : ctrl_r[hssd_pkg::HSSD_CTRL_LAMP_BIT];
	// Software gate lets the host blank the digit without a pin
	assign eff_gate = pin_gate_f || ctrl_r[hssd_pkg::HSSD_CTRL_GATE_BIT]; // [RL7] [RL8]

	hssd_decode u_decode
	(
		.digit_code(eff_code),
		.ripple_blank_in_n(pin_rbi_f), // [RL6] [RL11]
		.lamp_check_all(eff_lamp),
		.intensity_gate(eff_gate),
		.segment_lit(dec_seg),
		.segment_drive_en(dec_drv),
		.ripple_blank_out_n(dec_rbo_n)
	);

	// Display outputs, one register stage and no other state
	logic [6:0] seg_r;
	logic drv_r;
	logic rbo_n_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			seg_r <= hssd_pkg::HSSD_SEG_NONE;
			drv_r <= 1'b0;
			rbo_n_r <= 1'b1;
		end
		else
		begin
			seg_r <= dec_seg; // [RL1] [RL13]
			drv_r <= dec_drv; // [RL7]
			rbo_n_r <= dec_rbo_n; // [RL5] [RL12]
		end
	end

	// Read channel
	// Data captured at the address edge, so status may be one edge old
	logic rvalid_r;
	logic arready_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic rvalid_nxt;
	logic [31:0] status_word;

	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[hssd_pkg::HSSD_STAT_SEG_LSB +: 7] = seg_r;
		status_word[hssd_pkg::HSSD_STAT_RBO_BIT] = rbo_n_r;
		status_word[hssd_pkg::HSSD_STAT_RBI_BIT] = pin_rbi_f;
		status_word[hssd_pkg::HSSD_STAT_GATE_BIT] = eff_gate;
		status_word[hssd_pkg::HSSD_STAT_CODE_LSB +: 4] = eff_code;
		status_word[hssd_pkg::HSSD_STAT_LAMP_BIT] = eff_lamp;
		status_word[hssd_pkg::HSSD_STAT_DRV_BIT] = drv_r;
	end

	always_comb
	begin
		rvalid_nxt = rvalid_r && !s_axi_rready;
		if (s_axi_arvalid && arready_r)
			rvalid_nxt = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= hssd_pkg::HSSD_RESP_OKAY;
		end
		else
		begin
			rvalid_r <= rvalid_nxt;
			arready_r <= !rvalid_nxt;
			if (s_axi_arvalid && arready_r)
			begin
				if (s_axi_araddr == ADDR_W'(hssd_pkg::HSSD_OFF_CTRL))
				begin
					rdata_r <= ctrl_r;
					rresp_r <= hssd_pkg::HSSD_RESP_OKAY;
				end
				else if (s_axi_araddr == ADDR_W'(hssd_pkg::HSSD_OFF_STATUS))
				begin
					rdata_r <= status_word;
					rresp_r <= hssd_pkg::HSSD_RESP_OKAY;
				end
				else
				begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= hssd_pkg::HSSD_RESP_DECERR;
				end
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign segment_lit = seg_r;
	assign segment_drive_en = drv_r;
	assign ripple_blank_out_n = rbo_n_r;

endmodule

/* testbench/hex_seven_segment_decoder_tb.sv */
/*
 Bench for the digit driver: register writes, pin modes, chain blanking.
 Assumes the register map and latencies of the package and hand-over.
*/
`timescale 1ns/1ns
module hex_seven_segment_decoder_tb;
	logic clk = 1'b0, rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF, digit_code = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic lamp_check_all = 1'b0, intensity_gate = 1'b0, up_zero = 1'b0, up_blank_n = 1'b1;
	logic ripple_blank_in_n, segment_drive_en, ripple_blank_out_n;
	logic [6:0] segment_lit;
	logic [6:0] pat [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
		7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
	int bad_count = 0, compares = 0, i;

	hssd_top dut
	(
		.clk(clk), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.digit_code(digit_code), .lamp_check_all(lamp_check_all),
		.intensity_gate(intensity_gate), .ripple_blank_in_n(ripple_blank_in_n),
		.segment_lit(segment_lit), .segment_drive_en(segment_drive_en),
		.ripple_blank_out_n(ripple_blank_out_n)
	);
	hssd_upper_digit upper (.upper_is_zero(up_zero), .upper_blank_in_n(up_blank_n),
		.blank_out_n(ripple_blank_in_n));

	initial
	begin
		forever #4 clk = ~clk;
	end

	task automatic final_report;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		bit ok;
		ok = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !ok; n++)
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				ok = 1;
				s_axi_bready <= 1'b0;
				chk("bresp", er, s_axi_bresp);
			end
		end
		if (!ok)
		begin
			bad_count++;
			final_report;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		bit ok;
		ok = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !ok; n++)
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				ok = 1;
				s_axi_rready <= 1'b0;
				chk("rdata", ed, s_axi_rdata);
				chk("rresp", er, s_axi_rresp);
			end
		end
		if (!ok)
		begin
			bad_count++;
			final_report;
		end
	endtask

	// Pin paths settle within five edges; eight gives margin
	task automatic show(input logic [6:0] es, input logic ed, input logic eb);
		repeat (8) @(posedge clk);
		chk("segments", es, segment_lit);
		chk("drive_en", ed, segment_drive_en);
		chk("blank_out", eb, ripple_blank_out_n);
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		show(7'h3F, 1'b1, 1'b1);
		for (i = 0; i < 16; i++)
		begin
			wr(8'h00, i, 2'h0);
			show(pat[i], 1'b1, 1'b1);
		end
		up_zero <= 1'b1;
		up_blank_n <= 1'b0;
		wr(8'h00, 32'h0, 2'h0);
		show(7'h00, 1'b1, 1'b0);
		wr(8'h00, 32'h5, 2'h0);
		show(7'h6D, 1'b1, 1'b1);
		wr(8'h00, 32'h10, 2'h0);
		show(7'h7F, 1'b1, 1'b0);
		intensity_gate <= 1'b1;
		show(7'h00, 1'b0, 1'b0);
		intensity_gate <= 1'b0;
		wr(8'h00, 32'h20, 2'h0);
		show(7'h00, 1'b0, 1'b0);
		up_blank_n <= 1'b1;
		digit_code <= 4'hA;
		wr(8'h00, 32'h100, 2'h0);
		show(7'h77, 1'b1, 1'b1);
		lamp_check_all <= 1'b1;
		show(7'h7F, 1'b1, 1'b1);
		rd(8'h04, 32'h0000_E9FF, 2'h0);
		// Duty-cycled gate: drivers follow each phase, chain output never drops
		for (i = 0; i < 4; i++)
		begin
			intensity_gate <= 1'b1;
			show(7'h00, 1'b0, 1'b1);
			intensity_gate <= 1'b0;
			show(7'h7F, 1'b1, 1'b1);
		end
		wr(8'h04, 32'h0, 2'h0);
		rd(8'h00, 32'h100, 2'h0);
		wr(8'h08, 32'h1, 2'h3);
		rd(8'h08, 32'h0, 2'h3);
		wr(8'h00, 32'hFFFF_FFFF, 2'h0);
		rd(8'h00, 32'h13F, 2'h0);
		// Byte enables: only byte 1 cleared, low byte kept
		s_axi_wstrb <= 4'h2;
		wr(8'h00, 32'h0, 2'h0);
		rd(8'h00, 32'h3F, 2'h0);
		final_report;
	end
endmodule

/* testbench/hssd_monitor.sv */
/*
 Checker for the digit driver: display and bus timing relations.
 Assumes it is bound to hssd_top and sees only its ports.
*/
`timescale 1ns/1ns
module hssd_monitor
(
	// Clock, reset, bus
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Pins
	input wire logic intensity_gate,
	input wire logic ripple_blank_in_n,
	input wire logic [6:0] segment_lit,
	input wire logic segment_drive_en,
	input wire logic ripple_blank_out_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Pin filter plus output flop needs five edges
	a_gate_off: assert property (intensity_gate [*8] |-> !segment_drive_en)
		else $error("drivers on under gate");
	a_dark_off: assert property (!segment_drive_en |-> segment_lit == 7'h00)
		else $error("segments lit while drivers off");
	a_blank_dark: assert property (!ripple_blank_out_n |-> segment_lit inside {7'h00, 7'h7F})
		else $error("blanked zero shows segments");
	a_rbo_idle: assert property (ripple_blank_in_n [*8] |-> ripple_blank_out_n)
		else $error("blank output low without blank input");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read data late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken during response");
endmodule

bind hssd_top hssd_monitor u_mon
(
	.clk(clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.intensity_gate(intensity_gate), .ripple_blank_in_n(ripple_blank_in_n),
	.segment_lit(segment_lit), .segment_drive_en(segment_drive_en),
	.ripple_blank_out_n(ripple_blank_out_n)
);

/* testbench/hssd_upper_digit.sv */
/*
 Higher neighbour digit: hands its blank output down the chain.
 Assumes the bench says whether that digit is a blanked zero.
*/
`timescale 1ns/1ns
module hssd_upper_digit
(
	// Neighbour state
	input wire logic upper_is_zero,
	input wire logic upper_blank_in_n,
	// Chain output
	output logic blank_out_n
);
	assign blank_out_n = !(upper_is_zero && !upper_blank_in_n);
endmodule
